// ==== logic/ucp_pkg.sv ====
package ucp_pkg;
  // register byte offsets
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_ISET      = 8'h04;
  localparam logic [7:0] REG_NOLOAD    = 8'h08;
  localparam logic [7:0] REG_OPDLY     = 8'h0c;
  localparam logic [7:0] REG_RLDLY     = 8'h10;
  localparam logic [7:0] REG_SETGRP    = 8'h14;
  localparam logic [7:0] REG_LOGSEL    = 8'h18;
  localparam logic [7:0] REG_STATUS    = 8'h1c;
  localparam logic [7:0] REG_EXPTIME   = 8'h20;
  localparam logic [7:0] REG_CNT_START = 8'h24;
  localparam logic [7:0] REG_CNT_TRIP  = 8'h28;
  localparam logic [7:0] REG_CNT_BLOCK = 8'h2c;
  localparam logic [7:0] REG_LOG_W0    = 8'h30;
  localparam logic [7:0] REG_LOG_W1    = 8'h34;
  localparam logic [7:0] REG_LOG_W2    = 8'h38;
  localparam logic [7:0] REG_LOG_W3    = 8'h3c;
  localparam int unsigned CFG_N = 7;

  // control register fields
  localparam int unsigned CTRL_EN_BIT   = 0;
  localparam int unsigned CTRL_MASK_LSB = 1;
  localparam int unsigned CTRL_CLR_BIT  = 8;

  // reset values and writable bits, in offset order
  localparam logic [31:0] CFG_RST [CFG_N] = '{
    32'h0000007f, 32'h00000032, 32'h00000014, 32'h000003e8,
    32'h00000000, 32'h00000000, 32'h00000000};
  localparam logic [31:0] CFG_MASK [CFG_N] = '{
    32'h0000007f, 32'h0000ffff, 32'h0000ffff, 32'h001fffff,
    32'h001fffff, 32'h00000007, 32'h0000000f};

  // timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned MS_NS         = 1000000;
  localparam int unsigned MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned PGM_CYCLE_MS  = 5;
  localparam int unsigned PRE_TRIG_MS   = 20;
  localparam int unsigned PRE_FAULT_MS  = 200;
  localparam int unsigned PRE_TRIG_N    = PRE_TRIG_MS / PGM_CYCLE_MS;
  localparam int unsigned PRE_FAULT_N   = PRE_FAULT_MS / PGM_CYCLE_MS;
  localparam int unsigned MAX_OP_MS     = 1800000;
  localparam int unsigned BLOCK_LEAD_MS = 5;
  localparam int unsigned RESET_PCT     = 103;
  localparam int unsigned PCT_FULL      = 100;
  localparam int unsigned LOG_DEPTH     = 12;

  typedef enum logic [1:0] {
    COND_NORMAL  = 2'b00,
    COND_START   = 2'b01,
    COND_TRIP    = 2'b10,
    COND_BLOCKED = 2'b11
  } ucp_cond_e;

  typedef struct packed {
    logic [2:0][15:0] mag;
  } ucp_meas_s;

  // flags: 0 start on, 1 start off, 2 trip on, 3 trip off,
  // 4 block on, 5 block off
  typedef struct packed {
    logic [31:0] stamp;
    logic [5:0]  flags;
  } ucp_event_s;

  typedef struct packed {
    logic [31:0] stamp;
    ucp_cond_e   code;
    logic [2:0]  phases;
    logic [2:0]  group;
    logic [15:0] pre_trig;
    logic [15:0] fault;
    logic [15:0] pre_fault;
    logic [20:0] remain;
  } ucp_rec_s;
endpackage

// ==== logic/ucp_fault_log.sv ====
`timescale 1ns/1ns
module ucp_fault_log #(
  parameter int unsigned DEPTH = ucp_pkg::LOG_DEPTH
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  input  wire logic              wr_en,
  input  wire ucp_pkg::ucp_rec_s wr_rec,
  input  wire logic [3:0]        rd_sel,
  output ucp_pkg::ucp_rec_s      rd_rec,
  output logic [3:0]             count
);
  if (DEPTH < 2 || DEPTH > 15) begin : g_bad
    $error("ucp_fault_log: DEPTH must be 2..15");
  end

  localparam logic [3:0] LAST = 4'(DEPTH - 1);
  localparam logic [4:0] DEP5 = 5'(DEPTH);

  ucp_pkg::ucp_rec_s mem_q [DEPTH];
  logic [3:0]        wp_q;
  logic [3:0]        cnt_q;

  wire logic [3:0] newest = (wp_q == 4'h0) ? LAST : wp_q - 4'h1;
  wire logic [4:0] wrapped = 5'(newest) + DEP5 - 5'(rd_sel);
  wire logic [3:0] rd_idx = (rd_sel > newest) ? wrapped[3:0]
                                              : newest - rd_sel;
  wire logic       rd_ok = rd_sel < cnt_q;

  assign rd_rec = rd_ok ? mem_q[rd_idx] : '0;
  assign count  = cnt_q;

  // oldest entry is simply overwritten once all are used
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        mem_q[i] <= '0;
      end else if (ce && wr_en && wp_q == 4'(i)) begin
        mem_q[i] <= wr_rec;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wp_q  <= 4'h0;
      cnt_q <= 4'h0;
    end else if (ce && wr_en) begin
      wp_q <= (wp_q == LAST) ? 4'h0 : wp_q + 4'h1;
      if (cnt_q != 4'(DEPTH)) begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end

  chk_log_wrap: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce && wr_en && wp_q == LAST |=> wp_q == 4'h0 && cnt_q == 4'(DEPTH))
    else $error("fault log pointer did not wrap");
endmodule

// ==== logic/ucp_top.sv ====
`timescale 1ns/1ns
module ucp_top #(
  parameter int unsigned MS_CYCLES = ucp_pkg::MS_CYCLES
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic               ce,
  input  wire logic               meas_valid,
  input  wire ucp_pkg::ucp_meas_s meas,
  input  wire logic               blk_in,
  input  wire logic               motor_running,
  input  wire logic [7:0]         awaddr,
  input  wire logic               awvalid,
  output logic                    awready,
  input  wire logic [31:0]        wdata,
  input  wire logic [3:0]         wstrb,
  input  wire logic               wvalid,
  output logic                    wready,
  output logic [1:0]              bresp,
  output logic                    bvalid,
  input  wire logic               bready,
  input  wire logic [7:0]         araddr,
  input  wire logic               arvalid,
  output logic                    arready,
  output logic [31:0]             rdata,
  output logic [1:0]              rresp,
  output logic                    rvalid,
  input  wire logic               rready,
  output logic                    stage_start,
  output logic                    stage_trip,
  output logic                    stage_blocked,
  output logic                    stage_stopped,
  output ucp_pkg::ucp_cond_e      stage_cond,
  output logic                    evt_valid,
  output ucp_pkg::ucp_event_s     evt
);
  if (MS_CYCLES < 2 || MS_CYCLES > 1048576) begin : g_bad
    $error("ucp_top: MS_CYCLES must be 2..1048576");
  end

  localparam logic [19:0] DIV_LAST = 20'(MS_CYCLES - 1);
  localparam logic [20:0] MAX_OP   = 21'(ucp_pkg::MAX_OP_MS);
  localparam logic [20:0] STEP_MS  = 21'(ucp_pkg::PGM_CYCLE_MS);
  localparam logic [22:0] PCT_RST  = 23'(ucp_pkg::RESET_PCT);
  localparam logic [22:0] PCT_ONE  = 23'(ucp_pkg::PCT_FULL);
  localparam logic [5:0]  HN       = 6'(ucp_pkg::PRE_FAULT_N);
  localparam logic [5:0]  TN       = 6'(ucp_pkg::PRE_TRIG_N);
  localparam logic [2:0]  CFGN     = 3'(ucp_pkg::CFG_N);
  localparam logic [1:0]  RESP_OK  = 2'h0;
  localparam logic [1:0]  RESP_ERR = 2'h2;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // bus slave state
  logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic        aw_have_q, w_have_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [31:0] cfg_q [ucp_pkg::CFG_N];
  logic [31:0] rd_word;
  logic        rd_ok;

  // stage state
  logic [2:0]         ph_pick_q;
  logic               start_q, trip_q, blocked_q, stopped_q;
  ucp_pkg::ucp_cond_e cond_q;
  logic [20:0]        op_ms_q, rel_ms_q, exp_q;
  logic [19:0]        div_q;
  logic [31:0]        stamp_q;
  logic               evt_valid_q;
  ucp_pkg::ucp_event_s evt_q;
  logic [31:0]        cnt_q [3];
  logic [15:0]        hist_q [ucp_pkg::PRE_FAULT_N];
  logic [5:0]         hp_q;
  logic [2:0]         below_set, above_rel, below_nl, ph_pick_d;
  ucp_pkg::ucp_rec_s  rec, log_rec;
  logic [3:0]         log_cnt;

  // write channel handshake; address and data taken in either order
  wire logic aw_take  = awvalid & awready_q;
  wire logic w_take   = wvalid & wready_q;
  wire logic do_write = aw_have_q & w_have_q & ~bvalid_q;
  wire logic aw_have_d = aw_take | (aw_have_q & ~do_write);
  wire logic w_have_d  = w_take | (w_have_q & ~do_write);
  wire logic bvalid_d  = do_write | (bvalid_q & ~bready);
  wire logic ar_take   = arvalid & arready_q;
  wire logic rvalid_d  = ar_take | (rvalid_q & ~rready);

  wire logic [5:0]  aw_word = aw_addr_q[7:2];
  wire logic [5:0]  ar_word = araddr[7:2];
  wire logic        wr_ok   = aw_word < 6'(CFGN);
  wire logic [31:0] bmask   = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
                               {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  wire logic [31:0] wmerge  = (cfg_q[aw_word[2:0]] & ~bmask)
                              | (w_data_q & bmask);
  wire logic        cnt_clr = do_write
                              && aw_word == ucp_pkg::REG_CTRL[7:2]
                              && w_data_q[ucp_pkg::CTRL_CLR_BIT]
                              && w_strb_q[1];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OK;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0;
      w_strb_q  <= 4'h0;
    end else if (ce) begin
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      awready_q <= ~aw_have_d;
      wready_q  <= ~w_have_d;
      bvalid_q  <= bvalid_d;
      if (aw_take) aw_addr_q <= awaddr;
      if (w_take) begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (do_write) bresp_q <= wr_ok ? RESP_OK : RESP_ERR;
    end
  end

  // settings registers; values take effect on the next program cycle, except LOGSEL, which selects the log entry for the next read
  for (genvar k = 0; k < ucp_pkg::CFG_N; k++) begin : g_cfg
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cfg_q[k] <= ucp_pkg::CFG_RST[k];
      end else if (ce && do_write && aw_word == 6'(k)) begin
        cfg_q[k] <= wmerge & ucp_pkg::CFG_MASK[k];
      end
    end
  end

  wire logic        stage_en = cfg_q[0][ucp_pkg::CTRL_EN_BIT];
  wire logic [5:0]  ev_mask  = cfg_q[0][ucp_pkg::CTRL_MASK_LSB +: 6];
  wire logic [15:0] iset     = cfg_q[1][15:0];
  wire logic [15:0] noload   = cfg_q[2][15:0];
  wire logic [20:0] opdly_r  = cfg_q[3][20:0];
  wire logic [20:0] rldly    = cfg_q[4][20:0];
  wire logic [2:0]  grp      = cfg_q[5][2:0];
  wire logic [3:0]  log_sel  = cfg_q[6][3:0];

  always_comb begin
    rd_word = 32'h0;
    rd_ok   = 1'b1;
    if (ar_word < 6'(CFGN)) begin
      rd_word = cfg_q[ar_word[2:0]];
    end else begin
      case (ar_word)
        ucp_pkg::REG_STATUS[7:2]:
          rd_word = {16'h0, log_cnt, 3'h0, stopped_q, ph_pick_q,
                     blocked_q, trip_q, start_q, cond_q};
        ucp_pkg::REG_EXPTIME[7:2]:   rd_word = {11'h0, exp_q};
        ucp_pkg::REG_CNT_START[7:2]: rd_word = cnt_q[0];
        ucp_pkg::REG_CNT_TRIP[7:2]:  rd_word = cnt_q[1];
        ucp_pkg::REG_CNT_BLOCK[7:2]: rd_word = cnt_q[2];
        ucp_pkg::REG_LOG_W0[7:2]:    rd_word = log_rec.stamp;
        ucp_pkg::REG_LOG_W1[7:2]:    rd_word = {11'h0, log_rec.remain};
        ucp_pkg::REG_LOG_W2[7:2]:
          rd_word = {log_rec.pre_trig, log_rec.fault};
        ucp_pkg::REG_LOG_W3[7:2]:
          rd_word = {log_rec.pre_fault, 8'h0, log_rec.code,
                     log_rec.phases, log_rec.group};
        default:                     rd_ok = 1'b0;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0;
      rresp_q   <= RESP_OK;
    end else if (ce) begin
      arready_q <= ~rvalid_d;
      rvalid_q  <= rvalid_d;
      if (ar_take) begin
        rdata_q <= rd_word;
        rresp_q <= rd_ok ? RESP_OK : RESP_ERR;
      end
    end
  end

  // per-phase pick-up with built-in release hysteresis
  wire logic [22:0] iset_rel = 23'(iset) * PCT_RST;
  wire logic locked = (&below_nl) | ~motor_running | ~stage_en;

  for (genvar p = 0; p < 3; p++) begin : g_ph
    wire logic [22:0] m100 = 23'(meas.mag[p]) * PCT_ONE;
    assign below_set[p] = meas.mag[p] < iset;
    assign above_rel[p] = m100 > iset_rel;
    assign below_nl[p]  = meas.mag[p] < noload;
    // a locked stage forgets its pick-up
    assign ph_pick_d[p] = ~locked & (ph_pick_q[p] ? ~above_rel[p]
                                                  : below_set[p]);
  end

  // everything below except the millisecond time stamp, the counter clear and the one-cycle evt_valid pulse moves once per 5 ms measurement set
  wire logic step     = ce & meas_valid;
  wire logic pick_any = |ph_pick_d;
  // blocking is taken as it stands when the set arrives
  wire logic start_d   = pick_any & ~blk_in;
  wire logic blocked_d = pick_any & blk_in;

  // definite time only; elapsed time survives a short drop-out
  wire logic [20:0] opdly = (opdly_r > MAX_OP) ? MAX_OP : opdly_r;
  wire logic [20:0] op_inc = (op_ms_q > MAX_OP - STEP_MS) ? MAX_OP
                                                         : op_ms_q + STEP_MS;
  wire logic [20:0] rel_inc = (rel_ms_q > MAX_OP - STEP_MS) ? MAX_OP
                                                           : rel_ms_q + STEP_MS;
  wire logic rel_done = rel_inc >= rldly;
  // blocking during start releases like a pick-up drop
  wire logic [20:0] op_ms_d = start_d ? op_inc
                              : (rel_done ? 21'h0 : op_ms_q);
  wire logic [20:0] rel_ms_d = start_d ? 21'h0 : rel_inc;
  wire logic trip_d = start_d & (op_ms_d >= opdly);
  wire logic [20:0] exp_d = !start_d ? opdly
                            : (trip_d ? 21'h0 : opdly - op_ms_d);
  wire ucp_pkg::ucp_cond_e cond_d =
    blocked_d ? ucp_pkg::COND_BLOCKED :
    trip_d    ? ucp_pkg::COND_TRIP    :
    start_d   ? ucp_pkg::COND_START   : ucp_pkg::COND_NORMAL;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ph_pick_q <= 3'h0;
      start_q   <= 1'b0;
      trip_q    <= 1'b0;
      blocked_q <= 1'b0;
      stopped_q <= 1'b0;
      cond_q    <= ucp_pkg::COND_NORMAL;
      op_ms_q   <= 21'h0;
      rel_ms_q  <= 21'h0;
      exp_q     <= 21'h0;
    end else if (step) begin
      ph_pick_q <= ph_pick_d;
      start_q   <= start_d;
      trip_q    <= trip_d;
      blocked_q <= blocked_d;
      stopped_q <= &below_nl;
      cond_q    <= cond_d;
      op_ms_q   <= op_ms_d;
      rel_ms_q  <= rel_ms_d;
      exp_q     <= exp_d;
    end
  end

  // millisecond time stamp
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q   <= 20'h0;
      stamp_q <= 32'h0;
    end else if (ce) begin
      if (div_q == DIV_LAST) begin
        div_q   <= 20'h0;
        stamp_q <= stamp_q + 32'h1;
      end else begin
        div_q <= div_q + 20'h1;
      end
    end
  end

  // edge events; the mask only filters what leaves the block
  wire logic [5:0] flags = {blocked_q & ~blocked_d, blocked_d & ~blocked_q,
                            trip_q & ~trip_d, trip_d & ~trip_q,
                            start_q & ~start_d, start_d & ~start_q};
  wire logic [5:0] ev_sel = flags & ev_mask;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_valid_q <= 1'b0;
      evt_q       <= '0;
    end else if (ce) begin
      evt_valid_q <= step & (|ev_sel);
      if (step && |ev_sel) begin
        evt_q.flags <= ev_sel;
        evt_q.stamp <= stamp_q;
      end
    end
  end

  // a clear in the same cycle as a count leaves the counter at 1
  for (genvar c = 0; c < 3; c++) begin : g_cnt
    wire logic bump = step & flags[2 * c];
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cnt_q[c] <= 32'h0;
      end else if (ce) begin
        if (cnt_clr) begin
          cnt_q[c] <= bump ? 32'h1 : 32'h0;
        end else if (bump) begin
          cnt_q[c] <= cnt_q[c] + 32'h1;
        end
      end
    end
  end

  // minimum phase magnitude history for pre-trigger values
  wire logic [15:0] m01  = (meas.mag[0] < meas.mag[1]) ? meas.mag[0]
                                                       : meas.mag[1];
  wire logic [15:0] mmin = (m01 < meas.mag[2]) ? m01 : meas.mag[2];
  wire logic [5:0] ix_trig = (hp_q >= TN) ? hp_q - TN : hp_q + HN - TN;

  for (genvar h = 0; h < ucp_pkg::PRE_FAULT_N; h++) begin : g_hist
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        hist_q[h] <= 16'h0;
      end else if (step && hp_q == 6'(h)) begin
        hist_q[h] <= mmin;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hp_q <= 6'h0;
    end else if (step) begin
      hp_q <= (hp_q == HN - 6'h1) ? 6'h0 : hp_q + 6'h1;
    end
  end

  // the oldest history slot is exactly 200 ms old
  wire logic rec_en = step & (flags[0] | flags[2] | flags[4]);
  assign rec.stamp     = stamp_q;
  assign rec.code      = cond_d;
  assign rec.phases    = ph_pick_d;
  assign rec.group     = grp;
  assign rec.pre_trig  = hist_q[ix_trig];
  assign rec.fault     = mmin;
  assign rec.pre_fault = hist_q[hp_q];
  assign rec.remain    = exp_d;

  ucp_fault_log #(
    .DEPTH (ucp_pkg::LOG_DEPTH)
  ) u_log (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .wr_en   (rec_en),
    .wr_rec  (rec),
    .rd_sel  (log_sel),
    .rd_rec  (log_rec),
    .count   (log_cnt)
  );

  assign awready       = awready_q;
  assign wready        = wready_q;
  assign bvalid        = bvalid_q;
  assign bresp         = bresp_q;
  assign arready       = arready_q;
  assign rvalid        = rvalid_q;
  assign rdata         = rdata_q;
  assign rresp         = rresp_q;
  assign stage_start   = start_q;
  assign stage_trip    = trip_q;
  assign stage_blocked = blocked_q;
  assign stage_stopped = stopped_q;
  assign stage_cond    = cond_q;
  assign evt_valid     = evt_valid_q;
  assign evt           = evt_q;

  chk_block_wins: assert property (
    step && pick_any && blk_in |=> blocked_q && !start_q && !trip_q)
    else $error("blocked pick-up did not raise blocked only");
  chk_start_raise: assert property (
    step && pick_any && !blk_in |=> start_q && !blocked_q)
    else $error("unblocked pick-up did not raise start");
  chk_lock_clear: assert property (
    step && (!motor_running || &below_nl) |=> !start_q && !blocked_q
      && ph_pick_q == 3'h0)
    else $error("locked stage kept a pick-up");
  chk_hyst_hold: assert property (
    step && !locked && ph_pick_q[0] && !above_rel[0] |=> ph_pick_q[0])
    else $error("pick-up released inside hysteresis band");
  // delay may be rewritten while trip stands, so judge it where trip rises
  chk_trip_start: assert property (
    trip_q |-> start_q && cond_q == ucp_pkg::COND_TRIP
      && (!$rose(trip_q) || op_ms_q >= $past(opdly)))
    else $error("trip without elapsed start");
  chk_exp_time: assert property (
    step && start_d && !trip_d |=> exp_q + op_ms_q == $past(opdly))
    else $error("expected time inconsistent with delay");
  chk_cnt_start: assert property (
    step && flags[0] && !cnt_clr |=> cnt_q[0] == $past(cnt_q[0]) + 32'h1)
    else $error("start counter missed an event");
  chk_evt_mask: assert property (
    evt_valid_q |-> (evt_q.flags & ~$past(ev_mask)) == 6'h0
      && evt_q.flags != 6'h0)
    else $error("event escaped its mask");
endmodule

// ==== tb/ucp_partner.sv ====
`timescale 1ns/1ns
module ucp_partner (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          req,
  input  wire logic [47:0]   mags,
  input  wire logic          blk,
  input  wire logic          run,
  output logic               meas_valid,
  output ucp_pkg::ucp_meas_s meas,
  output logic               blk_in,
  output logic               motor_running
);
  // one set per request, standing for one 5 ms cycle
  // stale magnitudes are inverted so an unqualified sample shows up
  always_ff @(posedge aclk) begin
    meas_valid <= aresetn & req;
    meas       <= req ? ucp_pkg::ucp_meas_s'(mags) : ~meas;
    if (!aresetn) begin
      blk_in        <= 1'b0;
      motor_running <= 1'b0;
    end else if (req) begin
      blk_in        <= blk;
      motor_running <= run;
    end
  end
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
  logic        aclk, aresetn, ce, req, blk, run, meas_valid, blk_in;
  logic        motor_running, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, evt_valid;
  logic        stage_start, stage_trip, stage_blocked, stage_stopped;
  logic [7:0]  awaddr, araddr;
  logic [3:0]  wstrb;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rsp;
  logic [47:0] mags;
  logic [12:0] st;
  int          fails, checked;
  ucp_pkg::ucp_meas_s  meas;
  ucp_pkg::ucp_cond_e  stage_cond;
  ucp_pkg::ucp_event_s evt;

  ucp_top #(.MS_CYCLES(10)) ucp_top_i (
    .aclk, .aresetn, .ce, .meas_valid, .meas, .blk_in, .motor_running,
    .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .stage_start, .stage_trip, .stage_blocked,
    .stage_stopped, .stage_cond, .evt_valid, .evt);
  ucp_partner ucp_partner_i (
    .aclk, .aresetn, .req, .mags, .blk, .run, .meas_valid, .meas,
    .blk_in, .motor_running);

  always #5 aclk = ~aclk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // bready and rready stay high, so every answer is taken at once
  // no local limit: only the watchdog ends a wait
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    rsp = bresp;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    araddr  <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd  = rdata;
    rsp = rresp;
  endtask

  // one program cycle; st = {evt_valid, flags, cond, start, trip, blk, stop}
  task automatic step(input logic [15:0] l1, l2, l3, input logic b, r);
    mags <= {l3, l2, l1};
    blk  <= b;
    run  <= r;
    req  <= 1'b1;
    @(posedge aclk);
    req <= 1'b0;
    @(posedge aclk);
    @(negedge aclk);
    st = {evt_valid, evt_valid ? evt.flags : 6'h00, stage_cond,
          stage_start, stage_trip, stage_blocked, stage_stopped};
    @(posedge aclk);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    {aclk, aresetn, req, blk, run, awvalid, wvalid, arvalid} = 8'h00;
    {ce, bready, rready, wstrb} = 7'h7f;
    {awaddr, araddr, wdata, mags} = 96'h0;
    fails = 0;
    checked = 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    for (int i = 0; i < ucp_pkg::CFG_N; i++) begin
      rd_reg(8'(4 * i));
      check(rd, ucp_pkg::CFG_RST[i]);
    end
    rd_reg(8'h40);
    check(rd, 32'h0);
    check(32'(rsp), 32'h2);
    wr(ucp_pkg::REG_STATUS, 32'h1);
    check(32'(rsp), 32'h2);
    $display("registers done");
    wr(ucp_pkg::REG_OPDLY, 32'h0000000a);
    check(32'(rsp), 32'h0);
    step(16'h0028, 16'h00c8, 16'h00c8, 1'b0, 1'b1);
    check(st, 13'h1058);
    step(16'h0028, 16'h00c8, 16'h0028, 1'b0, 1'b1);
    check(st, 13'h112c);
    // L1 inside the release band holds, L3 recovers
    step(16'h0033, 16'h00c8, 16'h00c8, 1'b0, 1'b1);
    check(st, 13'h002c);
    step(16'h0034, 16'h00c8, 16'h00c8, 1'b0, 1'b1);
    check(st, 13'h1280);
    rd_reg(ucp_pkg::REG_EXPTIME);
    check(rd, 32'h0000000a);
    check(32'(rsp), 32'h0);
    $display("trip done");
    step(16'h00c8, 16'h00c8, 16'h0028, 1'b1, 1'b1);
    check(st, 13'h1432);
    step(16'h00c8, 16'h00c8, 16'h00c8, 1'b0, 1'b1);
    check(st, 13'h1800);
    step(16'h0028, 16'h0028, 16'h00c8, 1'b0, 1'b1);
    check(st, 13'h1058);
    step(16'h0028, 16'h0028, 16'h00c8, 1'b1, 1'b1);
    check(st, 13'h14b2);
    step(16'h00c8, 16'h00c8, 16'h00c8, 1'b0, 1'b1);
    check(st, 13'h1800);
    $display("blocking done");
    step(16'h0028, 16'h00c8, 16'h00c8, 1'b0, 1'b0);
    check(st, 13'h0000);
    step(16'h000a, 16'h000a, 16'h000a, 1'b0, 1'b1);
    check(st, 13'h0001);
    $display("lock done");
    wr(ucp_pkg::REG_CTRL, 32'h00000003);
    wr(ucp_pkg::REG_ISET, 32'h00000064);
    step(16'h0050, 16'h00c8, 16'h00c8, 1'b0, 1'b1);
    check(st, 13'h1058);
    step(16'h00c8, 16'h00c8, 16'h00c8, 1'b0, 1'b1);
    check(st, 13'h0000);
    rd_reg(ucp_pkg::REG_STATUS);
    check(rd, 32'h00006000);
    // newest record is the start at 0.80 In, delay 10 ms
    rd_reg(ucp_pkg::REG_LOG_W0);
    check(rd, evt.stamp);
    rd_reg(ucp_pkg::REG_LOG_W1);
    check(rd, 32'h00000005);
    rd_reg(ucp_pkg::REG_LOG_W2);
    check(rd, 32'h00280050);
    rd_reg(ucp_pkg::REG_LOG_W3);
    check(rd, 32'h00000048);
    wr(ucp_pkg::REG_LOGSEL, 32'h00000001);
    rd_reg(ucp_pkg::REG_LOG_W2);
    check(rd, 32'h00340028);
    rd_reg(ucp_pkg::REG_LOG_W3);
    check(rd, 32'h000000d8);
    rd_reg(ucp_pkg::REG_CNT_START);
    check(rd, 32'h3);
    rd_reg(ucp_pkg::REG_CNT_TRIP);
    check(rd, 32'h1);
    rd_reg(ucp_pkg::REG_CNT_BLOCK);
    check(rd, 32'h2);
    wr(ucp_pkg::REG_CTRL, 32'h00000103);
    rd_reg(ucp_pkg::REG_CNT_START);
    check(rd, 32'h0);
    // six more records fill the log and wrap its pointer
    for (int i = 0; i < 3; i++) begin
      step(16'h0050, 16'h00c8, 16'h00c8, 1'b1, 1'b1);
      step(16'h0050, 16'h00c8, 16'h00c8, 1'b0, 1'b1);
    end
    check(st, 13'h1058);
    rd_reg(ucp_pkg::REG_STATUS);
    check(rd, 32'h0000c025);
    rd_reg(ucp_pkg::REG_CNT_BLOCK);
    check(rd, 32'h3);
    $display("counters done");
    conclude();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    conclude();
  end
endmodule
